// file: src/ecsd_map.svh
// Register offsets, field positions, reset values and the general select count
// of the external chip select decoder. Included by the package and design.
`ifndef ECSD_MAP_SVH
`define ECSD_MAP_SVH

// Register offsets (byte addresses on the plain register port)
`define ECSD_FNEN_OFS     8'h40
`define ECSD_PGEND_OFS    8'h41
`define ECSD_PGSTART_OFS  8'h42
`define ECSD_VCSTART_OFS  8'h43
`define ECSD_MXHI_OFS     8'h44
`define ECSD_MXLO_OFS     8'h45
`define ECSD_GPSTART_OFS  8'h46
`define ECSD_GPEND_OFS    8'h47
`define ECSD_GP5END_OFS   8'h4F
`define ECSD_STATUS_OFS   8'h50

// Field layout
`define ECSD_RANGE_MSB    7
`define ECSD_RANGE_LSB    2
`define ECSD_MEM_MSB      2
`define ECSD_MEM_LSB      1
`define ECSD_FNEN0_BIT    0
`define ECSD_MXHI_MASK    8'hC0
`define ECSD_RANGE_MASK   8'hFC

// Reset values
`define ECSD_PGSTART_RST_EXP  8'h01
`define ECSD_PGSTART_RST_TEST 8'h00
`define ECSD_ZERO8            8'h00

// Number of general-purpose selects
`define ECSD_NGP          5

`endif

// file: src/ecsd_pkg.sv
// Types of the external chip select decoder.
// Assumes ecsd_map.svh is on the include path.
`include "ecsd_map.svh"
package ecsd_pkg;

  typedef enum logic [1:0] {
    ECSD_MEM_NONE,
    ECSD_MEM_64K,
    ECSD_MEM_128K,
    ECSD_MEM_256K
  } ecsd_mem_t;

  // One CPU bus cycle request
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } ecsd_cpu_t;

  // Resolved external address and extra address lines
  typedef struct packed {
    logic [1:0]  xa;
    logic [15:0] addr;
  } ecsd_ext_t;

  // Winner of the priority decode
  typedef enum logic [2:0] {
    ECSD_WIN_NONE,
    ECSD_WIN_ONCHIP,
    ECSD_WIN_VEC,
    ECSD_WIN_PROG,
    ECSD_WIN_GP
  } ecsd_win_t;

endpackage

// file: src/ecsd_top.sv
// External chip select decoder: range registers, priority decode, page
// translation, clock stretch and port G direction forcing.
// Assumes ref_clk is the E clock and the CPU address is on the same clock;
// on-chip hits come from the internal decoder on the same clock.
`include "ecsd_map.svh"

// Function
// R01: Five enabled active-low general selects assert inside their own range.
// R02: General selects compare address bits 15:10; start register holds stretch.
// R03: Stretch code gives zero to three extra E cycles.
// R04: Enabled general select forces its port G pin to output.
// R05: Program select asserts for start <= addr[15:10] < end; the code also requires test mode or expansion mode.
// R06: In expansion mode the program window modifies the outgoing address.
// R07: Out of reset in expanded mode vector select covers all space.
// R08: Vector select asserts from its start up to the top address.
// R09: Vector access drives logical address, extra lines forced high.
// R10: Program/vector stretch resets to one cycle expanded, zero in test.
// R11: Enabled vector select forces port G pin 0 to output.
// R12: Priority: registers, boot ROM, RAM, vector, program, general 1 to 5.
// R13: Selects and extra lines idle high from reset.
// R14: Low offset register holds bits 15:10 in 7:2, resets zero.
// R15: Vector start holds bits 15:10 in 7:2, resets zero.
// R16: Program start holds start bits 7:2 and stretch bits 1:0.
// R17: General select 5 end holds bits 7:2, low bits zero, resets zero.
// R18: Software sets program range before changing vector range.
// R19: Two-bit mode field selects none, 64K, 128K or 256K expansion.
// R20: Window adds CPU address to offset, extended onto extra lines.
// R21: Port G enable bits 7:3 enable general selects 1 to 5.
// R22: Program select reaches its pin only while enable bit 0 is set.
// R23: Only the winning select's stretch is applied per access.
// R24: Range writes take effect from the next bus cycle; the code drops writes made during a stretch.
module ecsd_top (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Mode strap, sampled after reset release
  input  wire logic               test_mode,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  // CPU bus cycle and on-chip hits
  input  wire ecsd_pkg::ecsd_cpu_t cpu,
  input  wire logic               hit_regs,
  input  wire logic               hit_boot,
  input  wire logic               hit_ram,
  // Port G direction bits
  input  wire logic [7:0]         portg_direction_bit,
  // External side
  output ecsd_pkg::ecsd_ext_t     ext,
  output logic                    program_select_n,
  output logic                    vector_select_n,
  output logic [4:0]              general_select_n,
  output logic [7:0]              portg_oe,
  output logic                    stretch_busy
);

  logic [7:0] fnen_r;
  logic [7:0] prog_start_r;
  logic [7:0] prog_end_r;
  logic [7:0] vec_start_r;
  logic [7:0] mx_hi_r;
  logic [7:0] mx_lo_r;
  logic [7:0] gp_start_r [`ECSD_NGP];
  logic [7:0] gp_end_r   [`ECSD_NGP];
  logic       vec_en_r;
  logic       strap_done_r;
  logic       test_r;
  logic [1:0] stretch_cnt_r;
  logic       busy_r;

  ecsd_pkg::ecsd_mem_t mem_mode;
  assign mem_mode = ecsd_pkg::ecsd_mem_t'(fnen_r[`ECSD_MEM_MSB:`ECSD_MEM_LSB]); // [R19]

  // Register writes are dropped while an access stretches, so ranges change only
  // between bus cycles
  logic wr_ok;
  assign wr_ok = reg_wr && !busy_r; // [R24]

  // Strap pin crosses into the E clock domain; no reset, so the level
  // has settled long before reset releases
  logic test_s1_r;
  logic test_s2_r;
  always_ff @(posedge ref_clk) begin
    test_s1_r <= test_mode;
    test_s2_r <= test_s1_r;
  end

  // Strap capture after release; reset cannot load a port value
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strap_done_r <= 1'b0;
      test_r       <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      test_r       <= test_s2_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fnen_r      <= `ECSD_ZERO8;
      prog_end_r  <= `ECSD_ZERO8;
      vec_start_r <= `ECSD_ZERO8; // [R15] [R07]
      mx_hi_r     <= `ECSD_ZERO8;
      mx_lo_r     <= `ECSD_ZERO8; // [R14]
    end else if (wr_ok) begin
      case (reg_addr)
        `ECSD_FNEN_OFS:    fnen_r      <= reg_wdata;
        `ECSD_PGEND_OFS:   prog_end_r  <= reg_wdata & `ECSD_RANGE_MASK;
        `ECSD_VCSTART_OFS: vec_start_r <= reg_wdata & `ECSD_RANGE_MASK; // [R15]
        `ECSD_MXHI_OFS:    mx_hi_r     <= reg_wdata & `ECSD_MXHI_MASK;
        `ECSD_MXLO_OFS:    mx_lo_r     <= reg_wdata & `ECSD_RANGE_MASK; // [R14]
        default: ;
      endcase
    end
  end

  // Program start: stretch reset differs by mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prog_start_r <= `ECSD_PGSTART_RST_EXP; // [R10]
    end else if (!strap_done_r) begin
      prog_start_r <= test_s2_r ? `ECSD_PGSTART_RST_TEST : `ECSD_PGSTART_RST_EXP; // [R10]
    end else if (wr_ok && reg_addr == `ECSD_PGSTART_OFS) begin
      prog_start_r <= reg_wdata; // [R16]
    end
  end

  // Vector select enabled out of reset in expanded mode only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vec_en_r <= 1'b1; // [R07]
    end else if (!strap_done_r) begin
      vec_en_r <= !test_s2_r;
    end
  end

  // General select range registers: indexed pairs, select 5 end fixed offset
  genvar g;
  generate
    for (g = 0; g < `ECSD_NGP; g++) begin : gp_regs
      localparam logic [7:0] SOFS = 8'(`ECSD_GPSTART_OFS + 2 * g);
      localparam logic [7:0] EOFS = (g == `ECSD_NGP - 1) ? `ECSD_GP5END_OFS
                                                         : 8'(`ECSD_GPEND_OFS + 2 * g);
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          gp_start_r[g] <= `ECSD_ZERO8;
          gp_end_r[g]   <= `ECSD_ZERO8; // [R17]
        end else if (wr_ok) begin
          if (reg_addr == SOFS) begin
            gp_start_r[g] <= reg_wdata; // [R02]
          end
          if (reg_addr == EOFS) begin
            gp_end_r[g] <= reg_wdata & `ECSD_RANGE_MASK; // [R17]
          end
        end
      end
    end
  endgenerate

  // Range compares on address bits 15:10
  logic [5:0] a_hi;
  logic [4:0] gp_hit;
  logic       vec_hit;
  logic       prog_hit;
  assign a_hi = cpu.addr[15:10];

  generate
    for (g = 0; g < `ECSD_NGP; g++) begin : gp_cmp
      // Inclusive end, matching the ending-address field meaning
      assign gp_hit[g] = fnen_r[3 + g]
        && a_hi >= gp_start_r[g][`ECSD_RANGE_MSB:`ECSD_RANGE_LSB]
        && a_hi <= gp_end_r[g][`ECSD_RANGE_MSB:`ECSD_RANGE_LSB]; // [R01] [R02] [R21]
    end
  endgenerate

  assign vec_hit  = vec_en_r
    && a_hi >= vec_start_r[`ECSD_RANGE_MSB:`ECSD_RANGE_LSB]; // [R08]
  assign prog_hit = (test_r || mem_mode != ecsd_pkg::ECSD_MEM_NONE)
    && a_hi >= prog_start_r[`ECSD_RANGE_MSB:`ECSD_RANGE_LSB]
    && a_hi <  prog_end_r[`ECSD_RANGE_MSB:`ECSD_RANGE_LSB]; // [R05]

  // Fixed priority resolution
  ecsd_pkg::ecsd_win_t win;
  logic [2:0]          gp_idx;
  always_comb begin
    win    = ecsd_pkg::ECSD_WIN_NONE;
    gp_idx = 3'h0;
    if (hit_regs || hit_boot || hit_ram) begin
      win = ecsd_pkg::ECSD_WIN_ONCHIP; // [R12]
    end else if (vec_hit) begin
      win = ecsd_pkg::ECSD_WIN_VEC;
    end else if (prog_hit) begin
      win = ecsd_pkg::ECSD_WIN_PROG;
    end else begin
      for (int i = `ECSD_NGP - 1; i >= 0; i--) begin
        if (gp_hit[i]) begin
          win    = ecsd_pkg::ECSD_WIN_GP; // [R12]
          gp_idx = 3'(i);
        end
      end
    end
  end

  // Stretch of the winner only
  logic [1:0] win_stretch;
  always_comb begin
    case (win)
      ecsd_pkg::ECSD_WIN_VEC,
      ecsd_pkg::ECSD_WIN_PROG: win_stretch = prog_start_r[1:0]; // [R23] [R10]
      ecsd_pkg::ECSD_WIN_GP:   win_stretch = gp_start_r[gp_idx][1:0]; // [R23]
      default:                 win_stretch = 2'h0;
    endcase
  end

  // Page translation
  logic [7:0]  page_sum;
  ecsd_pkg::ecsd_ext_t ext_nxt;
  assign page_sum = 8'({mx_hi_r[7:6], mx_lo_r[7:2]} + {2'h0, a_hi}); // [R20]
  always_comb begin
    ext_nxt.addr = cpu.addr;
    ext_nxt.xa   = 2'h3; // [R13]
    if (win == ecsd_pkg::ECSD_WIN_VEC) begin
      ext_nxt.xa = 2'h3; // [R09]
    end else if (win == ecsd_pkg::ECSD_WIN_PROG && mem_mode != ecsd_pkg::ECSD_MEM_NONE) begin
      ext_nxt.addr[15:10] = page_sum[5:0]; // [R06] [R20]
      if (mem_mode != ecsd_pkg::ECSD_MEM_64K) begin
        ext_nxt.xa[0] = page_sum[6];
      end
      if (mem_mode == ecsd_pkg::ECSD_MEM_256K) begin
        ext_nxt.xa[1] = page_sum[7];
      end
    end
  end

  // Access tracking: selects and address hold through the stretch
  logic start;
  assign start = cpu.valid && !busy_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_r        <= 1'b0;
      stretch_cnt_r <= 2'h0;
    end else if (start) begin
      busy_r        <= win_stretch != 2'h0; // [R03]
      stretch_cnt_r <= win_stretch;
    end else if (busy_r) begin
      stretch_cnt_r <= stretch_cnt_r - 2'h1;
      busy_r        <= stretch_cnt_r != 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      program_select_n <= 1'b1; // [R13]
      vector_select_n  <= 1'b1;
      general_select_n <= 5'h1F;
      ext              <= '{xa: 2'h3, addr: 16'hFFFF};
    end else if (start) begin
      program_select_n <= !(win == ecsd_pkg::ECSD_WIN_PROG && fnen_r[`ECSD_FNEN0_BIT]); // [R22]
      vector_select_n  <= !(win == ecsd_pkg::ECSD_WIN_VEC); // [R08]
      general_select_n <= (win == ecsd_pkg::ECSD_WIN_GP) ? ~(5'h01 << gp_idx) : 5'h1F; // [R01]
      ext              <= ext_nxt;
    end else if (!busy_r) begin
      program_select_n <= 1'b1;
      vector_select_n  <= 1'b1;
      general_select_n <= 5'h1F;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stretch_busy <= 1'b0;
    end else begin
      stretch_busy <= start ? (win_stretch != 2'h0) : (busy_r && stretch_cnt_r != 2'h1); // [R03]
    end
  end

  // Direction forcing on port G
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      portg_oe <= 8'h00;
    end else begin
      portg_oe[7:3] <= portg_direction_bit[7:3] | fnen_r[7:3]; // [R04]
      portg_oe[2]   <= portg_direction_bit[2] | (mem_mode == ecsd_pkg::ECSD_MEM_256K);
      portg_oe[1]   <= portg_direction_bit[1] | fnen_r[`ECSD_MEM_MSB];
      portg_oe[0]   <= portg_direction_bit[0] | vec_en_r | fnen_r[`ECSD_FNEN0_BIT]; // [R11]
    end
  end

  // Read port, data in the cycle after the strobe
  logic [7:0] rd_nxt;
  always_comb begin
    rd_nxt = `ECSD_ZERO8;
    case (reg_addr)
      `ECSD_FNEN_OFS:    rd_nxt = fnen_r;
      `ECSD_PGEND_OFS:   rd_nxt = prog_end_r;
      `ECSD_PGSTART_OFS: rd_nxt = prog_start_r;
      `ECSD_VCSTART_OFS: rd_nxt = vec_start_r;
      `ECSD_MXHI_OFS:    rd_nxt = mx_hi_r;
      `ECSD_MXLO_OFS:    rd_nxt = mx_lo_r;
      `ECSD_STATUS_OFS:  rd_nxt = {5'h00, vec_en_r, test_r, busy_r};
      default: begin
        for (int i = 0; i < `ECSD_NGP; i++) begin
          if (reg_addr == 8'(`ECSD_GPSTART_OFS + 2 * i)) begin
            rd_nxt = gp_start_r[i];
          end
          if (reg_addr == ((i == `ECSD_NGP - 1) ? `ECSD_GP5END_OFS
                                                : 8'(`ECSD_GPEND_OFS + 2 * i))) begin
            rd_nxt = gp_end_r[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= `ECSD_ZERO8;
    end else begin
      reg_rdata <= reg_rd ? rd_nxt : `ECSD_ZERO8;
    end
  end

  // Checks
  a_vec_over_prog: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
    (start && vec_hit && !hit_regs && !hit_boot && !hit_ram)
      |=> !vector_select_n && program_select_n)
    else $error("vector select lost priority");
  a_onchip_none: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
    (start && hit_regs) |=> vector_select_n && program_select_n && &general_select_n)
    else $error("select asserted over on-chip hit");
  a_gp_one_hot: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
    $onehot0(~general_select_n))
    else $error("two general selects at once");
  a_stretch_len: assert property (@(posedge ref_clk) disable iff (rst) // [R03]
    (start && win_stretch == 2'h3) |=> stretch_busy [*3] ##1 !stretch_busy)
    else $error("three-cycle stretch wrong");
  a_stretch_none: assert property (@(posedge ref_clk) disable iff (rst) // [R03]
    (start && win_stretch == 2'h0) |=> !stretch_busy)
    else $error("stretch without a stretch setting");
  a_vec_xa_high: assert property (@(posedge ref_clk) disable iff (rst) // [R09]
    (start && win == ecsd_pkg::ECSD_WIN_VEC)
      |=> !vector_select_n && ext.xa == 2'h3 && ext.addr == $past(cpu.addr))
    else $error("vector address modified");
  a_vec_off_test: assert property (@(posedge ref_clk) disable iff (rst) // [R07]
    (strap_done_r && test_r) |-> vector_select_n)
    else $error("vector select active in test mode");
  a_page_low: assert property (@(posedge ref_clk) disable iff (rst) // [R06]
    (start && win == ecsd_pkg::ECSD_WIN_PROG)
      |=> ext.addr[9:0] == $past(cpu.addr[9:0]))
    else $error("window access changed low address bits");
  a_xa_outside: assert property (@(posedge ref_clk) disable iff (rst) // [R13]
    (start && win != ecsd_pkg::ECSD_WIN_PROG) |=> ext.xa == 2'h3)
    else $error("extra page lines low outside window");
  a_prog_pin_gate: assert property (@(posedge ref_clk) disable iff (rst) // [R22]
    (start && win == ecsd_pkg::ECSD_WIN_PROG && !fnen_r[`ECSD_FNEN0_BIT])
      |=> program_select_n)
    else $error("program select without pin enable");
  a_gp_pin_gate: assert property (@(posedge ref_clk) disable iff (rst) // [R21]
    (start && !fnen_r[3]) |=> general_select_n[0])
    else $error("general select 1 without its enable");
  a_gp_oe_force: assert property (@(posedge ref_clk) disable iff (rst) // [R04]
    $past(fnen_r[7]) |-> portg_oe[7])
    else $error("general select pin not forced out");
  a_pin0_force: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    vec_en_r |=> portg_oe[0])
    else $error("port G pin 0 not forced out");
  a_prog_end_excl: assert property (@(posedge ref_clk) disable iff (rst) // [R05]
    (start && a_hi == prog_end_r[7:2] && !vec_hit) |=> program_select_n)
    else $error("program select at end field");
  a_sel_hold: assert property (@(posedge ref_clk) disable iff (rst) // [R24]
    busy_r |=> $stable(ext) && $stable(general_select_n))
    else $error("select changed during stretch");

endmodule

// file: verif/ecsd_ext_mem.sv
// Model of the devices on the expansion bus: counts the selects that claim
// a cycle and shows the level seen on port G pin 0, the pull-up when undriven.
// Assumes active-low selects and the decoder's port G output enables.
module ecsd_ext_mem (
  // Decoder selects
  input  wire logic       program_select_n,
  input  wire logic       vector_select_n,
  input  wire logic [4:0] general_select_n,
  // Port G enables
  input  wire logic [7:0] portg_oe,
  // Observed view
  output logic      [2:0] active_cnt,
  output logic            pin0_level
);
  // Two devices answering at once would fight on the data bus
  always_comb begin
    active_cnt = 3'($countones(~{program_select_n, vector_select_n, general_select_n}));
  end

  // Undriven pin floats to the pull-up, never to the last value
  always_comb begin
    pin0_level = portg_oe[0] ? (program_select_n & vector_select_n) : 1'b1;
  end
endmodule

// file: verif/tb_top.sv
// Testbench for the external chip select decoder: register port tasks and
// CPU bus cycles compared against expected selects, address and stretch.
// Assumes ecsd_pkg is compiled first; strap expanded, then test mode after a
// second reset at the end.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk;
  logic                rst;
  logic [7:0]          reg_addr;
  logic [7:0]          reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [7:0]          reg_rdata;
  ecsd_pkg::ecsd_cpu_t cpu;
  logic [2:0]          hit;
  logic [7:0]          dir;
  ecsd_pkg::ecsd_ext_t ext;
  logic                prog_n;
  logic                vec_n;
  logic [4:0]          gp_n;
  logic [7:0]          oe;
  logic                busy;
  logic [2:0]          act;
  logic                pin0;
  logic                strap;
  int                  fail_count;
  int                  cmp_count;

  ecsd_top u_dut (
    .ref_clk(ref_clk), .rst(rst), .test_mode(strap),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu(cpu), .hit_regs(hit[2]), .hit_boot(hit[1]),
    .hit_ram(hit[0]), .portg_direction_bit(dir), .ext(ext), .program_select_n(prog_n),
    .vector_select_n(vec_n), .general_select_n(gp_n), .portg_oe(oe), .stretch_busy(busy)
  );

  ecsd_ext_mem u_mem (
    .program_select_n(prog_n), .vector_select_n(vec_n), .general_select_n(gp_n),
    .portg_oe(oe), .active_cnt(act), .pin0_level(pin0)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [17:0] e, logic [17:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {10'h000, e}, {10'h000, reg_rdata});
  endtask

  // Winner w: 0 none, 1 vector, 2 program, 3 to 7 general 1 to 5
  task automatic acc(logic [15:0] a, logic [2:0] h, int w, logic [17:0] e,
                     logic [17:0] m, int st);
    int         n;
    logic [4:0] g;
    g = (w >= 3) ? 5'(5'h01 << (w - 3)) : 5'h00;
    @(posedge ref_clk);
    cpu <= '{valid: 1'b1, addr: a};
    hit <= h;
    @(posedge ref_clk);
    cpu.valid <= 1'b0;
    hit       <= 3'h0;
    #1;
    chk("selects", {11'h000, w != 1, w != 2, ~g}, {11'h000, vec_n, prog_n, gp_n});
    chk("ext", e & m, ext & m);
    chk("winners", 18'(w != 0), 18'(act));
    n = 0;
    // Bounded so a stuck stretch cannot hang the run
    while (busy === 1'b1 && n < 8) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    if (st >= 0) chk("stretch", 18'(st), 18'(n));
    @(posedge ref_clk);
    #1 chk("idle", 18'h0007F, {11'h000, vec_n, prog_n, gp_n});
  endtask

  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    logic [7:0]  mr [3] = '{8'h4F, 8'h45, 8'h43};
    logic [17:0] mk [4] = '{18'h3FFFF, 18'h0FFFF, 18'h1FFFF, 18'h3FFFF};
    fail_count = 0;
    cmp_count  = 0;
    rst        = 1'b1;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    cpu        = '{valid: 1'b0, addr: 16'h0000};
    hit        = 3'h0;
    dir        = 8'h00;
    strap      = 1'b0;
    repeat (7) @(posedge ref_clk);
    #1 chk("reset selects", 18'h0007F, {11'h000, vec_n, prog_n, gp_n});
    chk("reset ext", 18'h3FFFF, ext);
    chk("reset pin0", 18'h1, 18'(pin0));
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(8'h42, 8'h01);
    rd(8'h43, 8'h00);
    rd(8'h45, 8'h00);
    rd(8'h4F, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h50, 8'h04);
    acc(16'h0000, 3'h0, 1, 18'h30000, 18'h3FFFF, 1);
    chk("oe pin0", 18'h1, 18'(oe[0]));
    for (int i = 0; i < 3; i++) begin
      acc(16'hFFFE, 3'(1 << i), 0, 18'h0, 18'h0, 0);
    end
    // Low bits of the end, offset and vector start registers are not implemented
    for (int i = 0; i < 3; i++) begin
      wr(mr[i], 8'hFF);
      rd(mr[i], 8'hFC);
    end
    wr(8'h40, 8'hFF);
    wr(8'h41, 8'hB0);
    wr(8'h42, 8'h62);
    wr(8'h43, 8'hFC);
    wr(8'h44, 8'h40);
    wr(8'h45, 8'h40);
    wr(8'h46, 8'h23);
    wr(8'h47, 8'h30);
    wr(8'h4E, 8'h30);
    wr(8'h4F, 8'h34);
    rd(8'h42, 8'h62);
    chk("oe general", 18'h1F, 18'(oe[7:3]));
    acc(16'h6123, 3'h0, 2, 18'h1A123, 18'h3FFFF, 2);
    acc(16'hAFFF, 3'h0, 2, 18'h1EFFF, 18'h3FFFF, 2);
    acc(16'hB000, 3'h0, 0, 18'h3B000, 18'h3FFFF, 0);
    acc(16'h5FFF, 3'h0, 0, 18'h35FFF, 18'h3FFFF, 0);
    acc(16'hFC00, 3'h0, 1, 18'h3FC00, 18'h3FFFF, 2);
    acc(16'hFBFF, 3'h0, 0, 18'h3FBFF, 18'h3FFFF, 0);
    acc(16'h3000, 3'h0, 3, 18'h33000, 18'h3FFFF, 3);
    acc(16'h3400, 3'h0, 7, 18'h33400, 18'h3FFFF, 0);
    acc(16'h3800, 3'h0, 0, 18'h33800, 18'h3FFFF, 0);
    acc(16'h3000, 3'h4, 0, 18'h0, 18'h0, 0);
    wr(8'h43, 8'hA4);
    acc(16'hA400, 3'h0, 1, 18'h3A400, 18'h3FFFF, 2);
    for (int m = 0; m < 4; m++) begin
      wr(8'h40, 8'hF9 | 8'(m << 1));
      acc(16'h6123, 3'h0, m ? 2 : 0, m ? 18'h1A123 : 18'h36123, mk[m], m ? 2 : 0);
      chk("oe pages", 18'((m == 3) ? 3 : (m == 2) ? 1 : 0), 18'(oe[2:1]));
    end
    wr(8'h40, 8'hFE);
    acc(16'h6123, 3'h0, 0, 18'h0, 18'h0, -1);
    wr(8'h40, 8'h07);
    dir <= 8'hA5;
    repeat (2) @(posedge ref_clk);
    #1 chk("oe direction", 18'h14, 18'(oe[7:3]));
    acc(16'h3000, 3'h0, 0, 18'h33000, 18'h3FFFF, -1);
    // Second reset, strap now in test mode
    strap <= 1'b1;
    rst   <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 chk("reset oe", 18'h0, 18'(oe));
    chk("reset pin0", 18'h1, 18'(pin0));
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(8'h42, 8'h00);
    rd(8'h50, 8'h02);
    acc(16'hFFFE, 3'h0, 0, 18'h3FFFE, 18'h3FFFF, 0);
    tally_and_finish();
  end
endmodule
